/* dv/phase_driver_model.sv */
`timescale 1ns/100ps
`default_nettype none
// behavioural phase driver stage for one axis: counts pattern advances
module phase_driver_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [4:0] phases,
  input wire logic active_high,
  output logic [7:0] moves_seen
);
  // energized windings after polarity decode
  logic [4:0] lit;
  // last energized pattern, chop gaps ignored
  logic [4:0] last_q;
  assign lit = active_high ? phases : ~phases;
  // count changes between two energized patterns only, so chopping never counts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last_q <= 5'h00;
      moves_seen <= 8'h00;
    end
    else if (lit != 5'h00 && lit != last_q)
    begin
      last_q <= lit;
      if (last_q != 5'h00)
        moves_seen <= moves_seen + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* dv/test_triple_axis_stepper_profile.sv */
`timescale 1ns/100ps
`default_nettype none
module test_triple_axis_stepper_profile
  import stepper_pkg::*;
;
  // one row: address, write data, refusal expected
  typedef struct packed {logic [15:0] a; logic [31:0] d; logic e;} row_t;
  localparam row_t ROWS [8] = '{
    '{16'h0300, 32'h8004_1414, 1'b0}, '{16'h0304, 32'hba00_0101, 1'b0},
    '{16'h0310, 32'h6bd4_14ff, 1'b0}, '{16'h0314, 32'h4100_1010, 1'b0},
    '{16'h0320, 32'h00c8_147d, 1'b0}, '{16'h0324, 32'h0704_2010, 1'b0},
    '{16'h0330, 32'h1234_5678, 1'b1}, '{16'h0700, 32'h0000_0001, 1'b1}};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [9:0] base_switch = 10'h00c;
  logic ext_user_clk = 1'b0;
  wire logic [31:0] prdata;
  wire logic pready;
  wire logic pslverr;
  wire logic [14:0] phase_drive_outputs;
  wire logic [2:0] step_pulse;
  wire logic [2:0] port_a_dir;
  wire logic [2:0] port_b_dir;
  wire logic [2:0] aux_out;
  wire logic [7:0] moves_seen;
  int mismatches = 0;
  int checks_done = 0;
  logic [31:0] r;
  logic e;
  int n;
  int t1;
  int steps;
  int base_moves;
  ////////////////////////////////////////////////////////////////////////////////
  triple_axis_stepper_profile #(.STILL_CYCLES(50)) triple_axis_stepper_profile_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .base_switch(base_switch), .ext_user_clk(ext_user_clk),
    .phase_drive_outputs(phase_drive_outputs), .step_pulse(step_pulse),
    .port_a_dir(port_a_dir), .port_b_dir(port_b_dir), .aux_out(aux_out));
  phase_driver_model phase_driver_model_inst (.pclk(pclk), .presetn(presetn),
    .phases(phase_drive_outputs[4:0]), .active_high(1'b1), .moves_seen(moves_seen));
  ////////////////////////////////////////////////////////////////////////////////
  // system clock
  initial forever #10 pclk = ~pclk;
  // free-running user step clock, ten system cycles a period
  int ext_div = 0;
  always @(posedge pclk)
  begin
    ext_div <= (ext_div == 4) ? 0 : ext_div + 1;
    if (ext_div == 4)
      ext_user_clk <= ~ext_user_clk;
  end
  // compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    if (k >= 20)
      chk(32'h0000_0000, 32'h0000_0001);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #300us;
    mismatches++;
    close_out();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, 16'h0300, 32'h0000_0000, r, e);
    chk(r, REG_RST); // cleared word after reset
    chk(32'({port_a_dir, port_b_dir, aux_out}), 32'h0000_0000); // direction and aux outputs after reset
    // host configures before moving; refusal probed first
    apb(1'b1, 16'h0318, 32'h0000_0001, r, e);
    chk(32'(e), 32'h0000_0001); // unconfigured axis refuses
    // dividers kept within range by the host
    foreach (ROWS[i])
    begin
      apb(1'b1, ROWS[i].a, ROWS[i].d, r, e);
      chk(32'(e), 32'(ROWS[i].e)); // window decode
      apb(1'b0, ROWS[i].a, 32'h0000_0000, r, e);
      chk(r, ROWS[i].e ? 32'h0000_0000 : ROWS[i].d); // each written word reads back, refused rows read zero
    end
    chk(32'({port_a_dir, port_b_dir, aux_out}), 32'h0000_0051); // levels
    chk(32'({phase_drive_outputs[4], phase_drive_outputs[9:8]}), 32'h0000_0003);
    // external clock chosen for exact step timing
    base_moves = moves_seen;
    apb(1'b1, 16'h0308, 32'h0000_0003, r, e);
    chk(32'(e), 32'h0000_0000); // configured axis accepts
    n = 0;
    steps = 0;
    t1 = 0;
    while (steps < 3 && n < 3000)
    begin
      @(posedge pclk);
      n++;
      if (step_pulse[0] === 1'b1)
      begin
        steps++;
        if (steps == 3)
          chk(32'(n - t1), 32'd200); // twenty user edges a step
        t1 = n;
      end
    end
    // phase model registers the last advance one edge after the pulse
    @(posedge pclk);
    chk(32'(steps), 32'd3); // short move completes
    chk(32'(moves_seen - base_moves), 32'd3); // one pattern advance a step
    apb(1'b0, 16'h030c, 32'h0000_0000, r, e);
    chk(r, 32'h0800_0000); // idle, not yet chopping
    repeat (60) @(posedge pclk);
    apb(1'b0, 16'h030c, 32'h0000_0000, r, e);
    chk(r, 32'h0c00_0000); // chopping after standstill delay
    apb(1'b1, 16'h0308, 32'h4000_0000, r, e);
    apb(1'b1, 16'h0308, 32'h0000_0001, r, e);
    chk(32'(e), 32'h0000_0001); // axis reset clears configuration
    // board clock with divider one, five phases, half step, long move
    apb(1'b1, 16'h0320, 32'hc004_1414, r, e);
    apb(1'b1, 16'h0324, 32'h0701_2010, r, e);
    apb(1'b1, 16'h0328, 32'h0100_0064, r, e);
    n = 0;
    steps = 0;
    t1 = 0;
    while (steps < 2 && n < 6000)
    begin
      @(posedge pclk);
      n++;
      if (step_pulse[2] === 1'b1)
      begin
        steps++;
        if (steps == 1)
          chk(32'(phase_drive_outputs[14:10]), 32'h0000_0003); // half step pairs phases
        else
          chk(32'(n - t1), 32'd2500); // forty board ticks a step
        t1 = n;
      end
    end
    chk(32'(steps), 32'd2); // board clock drives steps
    // stop halts at once and keeps the count left
    apb(1'b1, 16'h0328, 32'h8000_0000, r, e);
    apb(1'b0, 16'h032c, 32'h0000_0000, r, e);
    chk(r, 32'h0800_0062); // no steps once stopped
    // hardware reset in the middle of a move
    apb(1'b1, 16'h0328, 32'h0100_0064, r, e);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(32'({step_pulse, aux_out, port_a_dir, pready, pslverr}), 32'h0000_0000);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, 16'h032c, 32'h0000_0000, r, e);
    chk(r, REG_RST); // reset leaves axis idle and unconfigured
    close_out();
  end
endmodule
`default_nettype wire

/* verilog/stepper_pkg.sv */
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// shared constants for the three-axis stepper profile generator
package stepper_pkg;

  // number of independent axes
  localparam int NUM_AXES = 3;
  // system clock rate
  localparam int CLK_HZ = 50_000_000;
  // internal step timebase, steps per second at divider one
  localparam int INT_STEP_HZ = 25_000;
  // on-board timebase ahead of the per-axis divider
  localparam int BOARD_STEP_HZ = 800_000;
  // standstill delay before chopping starts
  localparam int STILL_MS = 100;
  localparam int STILL_CYC = CLK_HZ / 1000 * STILL_MS;
  // chop unit: one 2.2 kHz period split into 48 units (16 on plus 32 off)
  localparam int CHOP_HZ = 2_200;
  localparam int CHOP_UNITS = 48;
  localparam int CHOP_UNIT_NS = 1_000_000_000 / (CHOP_HZ * CHOP_UNITS);
  localparam int CHOP_UNIT_CYC = CHOP_UNIT_NS * (CLK_HZ / 1_000_000) / 1000;

  ////////////////////////////////////////////////////////////////////////////////
  // register offsets within one axis block; axis in address bits 5:4
  localparam logic [3:0] OFS_CFG = 4'h0;
  localparam logic [3:0] OFS_SETUP = 4'h4;
  localparam logic [3:0] OFS_MOVE = 4'h8;
  localparam logic [3:0] OFS_STAT = 4'hC;
  localparam logic [31:0] REG_RST = 32'h0000_0000;

  // cfg fields
  localparam int CFG_SDIV = 0;
  localparam int CFG_RDIV = 8;
  localparam int CFG_RAMP = 16;
  localparam int CFG_HALF = 30;
  localparam int CFG_POL = 31;
  // setup fields
  localparam int SU_ON = 0;
  localparam int SU_OFF = 8;
  localparam int SU_XDIV = 16;
  localparam int SU_MOTOR = 24;
  localparam int SU_CSRC = 26;
  localparam int SU_CHOP = 28;
  localparam int SU_PDIR = 29;
  localparam int SU_AUX = 31;
  // move fields
  localparam int MV_DIR = 24;
  localparam int MV_RESET = 30;
  localparam int MV_STOP = 31;

  // motor codes
  localparam logic [1:0] MOTOR_3PH = 2'h1;
  localparam logic [1:0] MOTOR_4PH = 2'h2;
  // clock sources
  localparam logic [1:0] CSRC_INT = 2'h0;
  localparam logic [1:0] CSRC_BOARD = 2'h1;
  localparam logic [1:0] CSRC_EXT = 2'h2;

  // motion states
  typedef enum logic [1:0] {AX_IDLE, AX_ACCEL, AX_RUN, AX_DECEL} axis_state_t;

endpackage
`default_nettype wire

/* verilog/triple_axis_stepper_profile.sv */
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module triple_axis_stepper_profile
  import stepper_pkg::*;
#(
  parameter int STILL_CYCLES = STILL_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [9:0] base_switch,
  input wire logic ext_user_clk,
  output logic [14:0] phase_drive_outputs,
  output logic [2:0] step_pulse,
  output logic [2:0] port_a_dir,
  output logic [2:0] port_b_dir,
  output logic [2:0] aux_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // per-axis state
  typedef struct packed {
    logic [7:0] sdiv; // start_rate_divider
    logic [7:0] rdiv; // run rate divider
    logic [13:0] ramp; // ramp step count
    logic half; // half step
    logic pol; // phase polarity
    logic [7:0] on_t; // chop on units
    logic [7:0] off_t; // chop off units
    logic [7:0] xdiv; // board prescale, divides by value plus one
    logic [1:0] motor; // motor code
    logic [1:0] csrc; // clock source
    logic chop_en; // standstill chopping
    logic [1:0] pdir; // port b, port a direction
    logic aux; // auxiliary level
    logic configured; // accepted config
    axis_state_t st; // motion state
    logic [23:0] remaining; // steps left
    logic [13:0] ramp_done; // ramp steps taken
    logic [15:0] acc; // ramp error accumulator
    logic [7:0] cur_div; // active divider
    logic [7:0] tcnt; // ticks in this step
    logic [7:0] xcnt; // board prescale count
    logic [3:0] pos; // sequence position
    logic dir; // step direction
    logic [22:0] still; // standstill timer
    logic [7:0] chop_cnt; // chop unit count
    logic chopping; // chopping active
    logic chop_on; // chop phase on
    logic [4:0] phase; // phase outputs
    logic step; // step pulse
  } axis_q_t;

  // whole module state
  typedef struct packed {
    axis_q_t [NUM_AXES-1:0] ax;
    logic [25:0] int_acc; // internal timebase accumulator
    logic [25:0] brd_acc; // board timebase accumulator
    logic [9:0] chop_pre; // chop unit prescaler
    logic ext_s1; // ext clock sync stage one
    logic ext_s2; // ext clock sync stage two
    logic ext_prev; // ext clock edge history
    logic [9:0] base_s1; // switch sync stage one
    logic [9:0] base_s2; // switch sync stage two
    logic pready; // access phase ready
    logic pslverr; // access error
    logic [31:0] prdata; // read data
  } state_t;

  state_t q;
  state_t d;

  ////////////////////////////////////////////////////////////////////////////////
  // fractional timebase step: {tick, new accumulator}
  function automatic logic [26:0] frac_step(input logic [25:0] acc, input int inc);
    logic [26:0] s;
    s = {1'b0, acc} + 27'(inc);
    if (s >= 27'(CLK_HZ))
      frac_step = {1'b1, 26'(s - 27'(CLK_HZ))};
    else
      frac_step = {1'b0, s[25:0]};
  endfunction

  // phases in use for a motor code
  function automatic logic [2:0] phase_count(input logic [1:0] motor);
    phase_count = 3'(motor) + 3'd2;
  endfunction

  // mask of driven phase outputs
  function automatic logic [4:0] phase_mask(input logic [1:0] motor);
    phase_mask = 5'(~(5'b11111 << phase_count(motor)));
  endfunction

  // energized phases for a sequence position
  function automatic logic [4:0] phase_pattern(input logic [3:0] pos, input logic [1:0] motor,
                                               input logic half);
    logic [2:0] idx;
    logic [2:0] nxt;
    idx = half ? pos[3:1] : pos[2:0];
    nxt = (idx + 3'd1 == phase_count(motor)) ? 3'd0 : idx + 3'd1;
    phase_pattern = 5'b00001 << idx;
    // odd half-step positions energize two neighbouring phases
    if (half && pos[0])
      phase_pattern = phase_pattern | (5'b00001 << nxt);
  endfunction

  // next sequence position with wrap in either direction
  function automatic logic [3:0] next_pos(input logic [3:0] pos, input logic dir,
                                          input logic [1:0] motor, input logic half);
    logic [3:0] last;
    last = half ? {phase_count(motor), 1'b0} - 4'd1 : {1'b0, phase_count(motor)} - 4'd1;
    if (dir)
      next_pos = (pos >= last) ? 4'd0 : pos + 4'd1;
    else
      next_pos = (pos == 4'd0 || pos > last) ? last : pos - 4'd1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // shared ticks
  logic [26:0] int_nx;
  logic [26:0] brd_nx;
  logic ext_edge;
  logic chop_tick;
  logic addr_hit;
  logic wr_commit;
  logic [1:0] sel_axis;
  assign int_nx = frac_step(q.int_acc, INT_STEP_HZ);
  assign brd_nx = frac_step(q.brd_acc, BOARD_STEP_HZ);
  assign ext_edge = q.ext_s2 & ~q.ext_prev;
  assign chop_tick = (q.chop_pre == 10'(CHOP_UNIT_CYC - 1));
  // board window follows the base switches
  assign addr_hit = (paddr[15:6] == q.base_s2) && (paddr[5:4] != 2'd3);
  assign sel_axis = paddr[5:4];
  assign wr_commit = psel & penable & q.pready & pwrite & ~q.pslverr;

  ////////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    logic base_tick;
    logic btick;
    logic [16:0] acc_sum;
    logic [7:0] diff;
    logic [4:0] pat;
    base_tick = 1'b0;
    btick = 1'b0;
    acc_sum = 17'd0;
    diff = 8'd0;
    pat = 5'd0;
    d = q;
    d.int_acc = int_nx[25:0];
    d.brd_acc = brd_nx[25:0];
    d.chop_pre = chop_tick ? 10'd0 : q.chop_pre + 10'd1;
    // two-stage synchronisers
    d.ext_s1 = ext_user_clk;
    d.ext_s2 = q.ext_s1;
    d.ext_prev = q.ext_s2;
    d.base_s1 = base_switch;
    d.base_s2 = q.base_s1;

    // apb setup cycle prepares the answer
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    d.prdata = REG_RST;
    if (psel && !penable)
    begin
      d.pready = 1'b1;
      // motion refused on an unconfigured axis
      if (!addr_hit || (pwrite && paddr[3:0] == OFS_MOVE && !q.ax[sel_axis].configured))
        d.pslverr = 1'b1;
      else if (!pwrite)
        case (paddr[3:0])
          OFS_CFG: d.prdata = {q.ax[sel_axis].pol, q.ax[sel_axis].half, q.ax[sel_axis].ramp,
                               q.ax[sel_axis].rdiv, q.ax[sel_axis].sdiv};
          OFS_SETUP: d.prdata = {q.ax[sel_axis].aux, q.ax[sel_axis].pdir,
                                 q.ax[sel_axis].chop_en, q.ax[sel_axis].csrc,
                                 q.ax[sel_axis].motor, q.ax[sel_axis].xdiv,
                                 q.ax[sel_axis].off_t, q.ax[sel_axis].on_t};
          OFS_STAT: d.prdata = {4'h0, q.ax[sel_axis].configured, q.ax[sel_axis].chopping,
                                2'(q.ax[sel_axis].st), q.ax[sel_axis].remaining};
          default: d.prdata = REG_RST;
        endcase
    end

    for (int i = 0; i < NUM_AXES; i++)
    begin
      d.ax[i].step = 1'b0;
      btick = 1'b0;
      if (brd_nx[26])
      begin
        if (q.ax[i].xcnt >= q.ax[i].xdiv)
        begin
          d.ax[i].xcnt = 8'd0;
          btick = 1'b1;
        end
        else
          d.ax[i].xcnt = q.ax[i].xcnt + 8'd1;
      end
      case (q.ax[i].csrc)
        CSRC_BOARD: base_tick = btick;
        CSRC_EXT: base_tick = ext_edge;
        default: base_tick = int_nx[26];
      endcase
      diff = (q.ax[i].sdiv > q.ax[i].rdiv) ? q.ax[i].sdiv - q.ax[i].rdiv : 8'd0;
      acc_sum = 17'(q.ax[i].acc) + 17'(diff);

      // one step per active divider period
      if (q.ax[i].st != AX_IDLE && base_tick)
      begin
        if (9'(q.ax[i].tcnt) + 9'd1 >= 9'(q.ax[i].cur_div))
        begin
          d.ax[i].tcnt = 8'd0;
          d.ax[i].step = 1'b1;
          d.ax[i].pos = next_pos(q.ax[i].pos, q.ax[i].dir, q.ax[i].motor, q.ax[i].half);
          d.ax[i].remaining = q.ax[i].remaining - 24'd1;
          // trapezoid, decel length mirrors accel length
          case (q.ax[i].st)
            AX_ACCEL:
            begin
              d.ax[i].ramp_done = q.ax[i].ramp_done + 14'd1;
              // divider walks down spread over the ramp
              if (acc_sum >= 17'(q.ax[i].ramp))
              begin
                d.ax[i].acc = 16'(acc_sum - 17'(q.ax[i].ramp));
                if (q.ax[i].cur_div > q.ax[i].rdiv)
                  d.ax[i].cur_div = q.ax[i].cur_div - 8'd1;
              end
              else
                d.ax[i].acc = acc_sum[15:0];
              if (q.ax[i].remaining - 24'd1 <= 24'(q.ax[i].ramp_done) + 24'd1)
              begin
                d.ax[i].st = AX_DECEL;
                d.ax[i].acc = 16'd0;
              end
              else if (q.ax[i].ramp_done + 14'd1 >= q.ax[i].ramp)
              begin
                d.ax[i].st = AX_RUN;
                d.ax[i].cur_div = q.ax[i].rdiv;
                d.ax[i].acc = 16'd0;
              end
            end
            AX_RUN:
              if (q.ax[i].remaining - 24'd1 <= 24'(q.ax[i].ramp_done))
                d.ax[i].st = AX_DECEL;
            AX_DECEL:
            begin
              if (q.ax[i].ramp_done != 14'd0)
                d.ax[i].ramp_done = q.ax[i].ramp_done - 14'd1;
              if (acc_sum >= 17'(q.ax[i].ramp))
              begin
                d.ax[i].acc = 16'(acc_sum - 17'(q.ax[i].ramp));
                if (q.ax[i].cur_div < q.ax[i].sdiv)
                  d.ax[i].cur_div = q.ax[i].cur_div + 8'd1;
              end
              else
                d.ax[i].acc = acc_sum[15:0];
            end
            default: d.ax[i].st = AX_IDLE;
          endcase
          if (q.ax[i].remaining <= 24'd1)
            d.ax[i].st = AX_IDLE;
        end
        else
          d.ax[i].tcnt = q.ax[i].tcnt + 8'd1;
      end

      if (q.ax[i].st != AX_IDLE || !q.ax[i].chop_en)
      begin
        d.ax[i].still = 23'd0;
        d.ax[i].chopping = 1'b0;
        d.ax[i].chop_on = 1'b0;
      end
      else if (!q.ax[i].chopping)
      begin
        if (q.ax[i].still >= 23'(STILL_CYCLES - 1))
        begin
          d.ax[i].chopping = 1'b1;
          d.ax[i].chop_on = 1'b1;
          d.ax[i].chop_cnt = 8'd0;
        end
        else
          d.ax[i].still = q.ax[i].still + 23'd1;
      end
      else if (chop_tick)
      begin
        // on and off times in chop units
        if (9'(q.ax[i].chop_cnt) + 9'd1 >= 9'(q.ax[i].chop_on ? q.ax[i].on_t : q.ax[i].off_t))
        begin
          d.ax[i].chop_cnt = 8'd0;
          d.ax[i].chop_on = ~q.ax[i].chop_on;
        end
        else
          d.ax[i].chop_cnt = q.ax[i].chop_cnt + 8'd1;
      end

      // writes land only in the addressed axis
      if (wr_commit && sel_axis == 2'(i))
        case (paddr[3:0])
          OFS_CFG:
          begin
            d.ax[i].sdiv = pwdata[CFG_SDIV +: 8];
            d.ax[i].rdiv = pwdata[CFG_RDIV +: 8];
            d.ax[i].ramp = pwdata[CFG_RAMP +: 14];
            d.ax[i].half = pwdata[CFG_HALF];
            d.ax[i].pol = pwdata[CFG_POL];
            d.ax[i].configured = 1'b1;
          end
          OFS_SETUP:
          begin
            d.ax[i].on_t = pwdata[SU_ON +: 8];
            d.ax[i].off_t = pwdata[SU_OFF +: 8];
            d.ax[i].xdiv = pwdata[SU_XDIV +: 8];
            d.ax[i].motor = pwdata[SU_MOTOR +: 2];
            d.ax[i].csrc = pwdata[SU_CSRC +: 2];
            d.ax[i].chop_en = pwdata[SU_CHOP];
            d.ax[i].pdir = pwdata[SU_PDIR +: 2];
            d.ax[i].aux = pwdata[SU_AUX];
          end
          OFS_MOVE:
            if (pwdata[MV_RESET])
              d.ax[i] = '0;
            else if (pwdata[MV_STOP])
              d.ax[i].st = AX_IDLE;
            else if (q.ax[i].st == AX_IDLE && pwdata[23:0] != 24'd0)
            begin
              // move starts at the start divider
              d.ax[i].st = AX_ACCEL;
              d.ax[i].cur_div = q.ax[i].sdiv;
              d.ax[i].remaining = pwdata[23:0];
              d.ax[i].dir = pwdata[MV_DIR];
              d.ax[i].ramp_done = 14'd0;
              d.ax[i].acc = 16'd0;
              d.ax[i].tcnt = 8'd0;
            end
          default: d.ax[i].step = d.ax[i].step;
        endcase

      pat = phase_pattern(d.ax[i].pos, d.ax[i].motor, d.ax[i].half) & phase_mask(d.ax[i].motor);
      if (d.ax[i].chopping && !d.ax[i].chop_on)
        pat = 5'd0;
      d.ax[i].phase = d.ax[i].pol ? pat : ~pat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '0;
    else
      q <= d;
  end

  // outputs straight from state
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  genvar g;
  for (g = 0; g < NUM_AXES; g++)
  begin : g_out
    assign phase_drive_outputs[g*5 +: 5] = q.ax[g].phase;
    assign step_pulse[g] = q.ax[g].step;
    assign port_a_dir[g] = q.ax[g].pdir[0];
    assign port_b_dir[g] = q.ax[g].pdir[1];
    assign aux_out[g] = q.ax[g].aux;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  for (g = 0; g < NUM_AXES; g++)
  begin : g_chk
    sequence start_cmd;
      wr_commit && sel_axis == 2'(g) && paddr[3:0] == OFS_MOVE && pwdata[31:30] == 2'b00 &&
        pwdata[23:0] != 24'd0 && q.ax[g].st == AX_IDLE;
    endsequence
    sequence other_write;
      wr_commit && sel_axis != 2'(g);
    endsequence
    start_div_a: assert property (start_cmd |=> q.ax[g].st == AX_ACCEL && q.ax[g].cur_div == q.ax[g].sdiv) else $error("move start divider");
    unconf_move_a: assert property (psel && !penable && pwrite && addr_hit && sel_axis == 2'(g) && paddr[3:0] == OFS_MOVE && !q.ax[g].configured |=> q.pslverr && q.pready) else $error("unconfigured move accepted");
    axis_apart_a: assert property (other_write ##0 (q.ax[g].st == AX_IDLE) |=> $stable(q.ax[g].sdiv) && $stable(q.ax[g].motor)) else $error("axis config crosstalk");
    run_div_a: assert property (q.ax[g].st == AX_RUN |-> q.ax[g].cur_div == q.ax[g].rdiv) else $error("run divider wrong");
    accel_down_a: assert property (q.ax[g].st == AX_ACCEL && $past(q.ax[g].st) == AX_ACCEL |-> q.ax[g].cur_div <= $past(q.ax[g].cur_div)) else $error("accel divider rose");
    ramp_len_a: assert property (q.ax[g].st != AX_IDLE |-> q.ax[g].ramp_done <= q.ax[g].ramp) else $error("ramp overrun");
    step_busy_a: assert property (q.ax[g].step |-> $past(q.ax[g].st) != AX_IDLE ##1 !q.ax[g].step) else $error("stray step");
    ext_tick_a: assert property (q.ax[g].csrc == CSRC_EXT && q.ax[g].st != AX_IDLE && $past(q.ax[g].st) != AX_IDLE && $changed(q.ax[g].tcnt) |-> $past(ext_edge)) else $error("ext timebase ignored");
    unused_ph_a: assert property (q.ax[g].motor == MOTOR_3PH |-> q.ax[g].phase[4:3] == {2{~q.ax[g].pol}}) else $error("unused phase driven");
    polarity_a: assert property (!q.ax[g].chopping && q.ax[g].motor == MOTOR_4PH |-> $countones(q.ax[g].pol ? q.ax[g].phase : ~q.ax[g].phase) inside {1, 2}) else $error("phase polarity");
    chop_move_a: assert property (q.ax[g].st != AX_IDLE || !q.ax[g].chop_en |-> !q.ax[g].chopping) else $error("chopping while moving");
    chop_wait_a: assert property ($rose(q.ax[g].chopping) |-> $past(q.ax[g].still) == 23'(STILL_CYCLES - 1)) else $error("chop delay wrong");
  end

endmodule
`default_nettype wire
